/* File: logic/sirqa_map.svh */
// Summary of operation
// (RULE1) Enable bit: 0 disables agent, default on
// (RULE2) Quiet start: one low clock, then release
// (RULE3) No start frame while a cycle runs
// (RULE4) Host extends start low to 4-8 clocks
// (RULE5) Level change in Quiet mode requests start
// (RULE6) Continuous mode: agent never starts a frame
// (RULE7) Mode changes only at stop; reset Continuous
// (RULE8) Frames counted from start rise, three clocks
// (RULE9) Sample clock: drive low only if low
// (RULE10) Recovery high after own low; turn-around release
// (RULE11) Frame N sample is 3N-1 after rise
// (RULE12) Frame map: 2=IRQ1, 3=SMI/IRQ2, 4-16=IRQ3-15
// (RULE13) Software picks one use for frame 3
// (RULE14) Frame 14 carries IRQ13
// (RULE15) Stop width: 2 Quiet, 3 Continuous
// (RULE16) Next start two clocks after stop rise
// (RULE17) Idle clocks after stop are optional
// (RULE18) Drive and sample on rising clock only
// (RULE19) Released during reset, leaves Continuous idle
// (RULE20) Host runs first cycle after reset
// (RULE21) Host delays EOI by one cycle latency
// (RULE22) Host goes Continuous before configuration change
// (RULE23) Disabled agent never drives the line
// (RULE24) Interrupt inputs synchronised before use
// (RULE25) Own start: follow host takeover and count
`ifndef SIRQA_MAP_SVH
`define SIRQA_MAP_SVH
`define SIRQA_NUM_FRAMES 5'h10
`define SIRQA_FIRST_FRAME 5'h01
`define SIRQA_FIRST_IRQ_FRAME 5'h02
`define SIRQA_STOP_QUIET 4'h2
`define SIRQA_STOP_CONT 4'h3
`define SIRQA_RUN_MAX 4'hF
`define SIRQA_SYNC_DLY 6'h02
`define SIRQA_K_MAX 6'h3F
`define SIRQA_FRAME_MAX 5'h1F
`define SIRQA_SENT_RESET 16'hFFFF
`define SIRQA_FRAME1_MASK 16'hFFFE
`endif

/* File: logic/sirqa_pkg.sv */
`default_nettype none
package sirqa_pkg;
    // Cycle tracking states
    typedef enum logic [1:0] {
        SIRQA_IDLE, SIRQA_OWN_START, SIRQA_START_LOW, SIRQA_FRAMES
    } sirqa_state_t;
    // Phase of the clock currently on the line
    typedef enum logic [1:0] {
        SIRQA_SAMPLE, SIRQA_RECOVER, SIRQA_TURN
    } sirqa_phase_t;
    // Start frame ownership mode
    typedef enum logic {SIRQA_CONT, SIRQA_QUIET} sirqa_mode_t;
endpackage
`default_nettype wire

/* File: logic/sirqa_sync.sv */
`default_nettype none
`include "sirqa_map.svh"
// Two-stage synchroniser, one pair of flops per bit
module sirqa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta; // First stage, read only by second
            // Idle level of every input is high
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    meta <= 1'b1;
                    syncOut[i] <= 1'b1;
                end else begin
                    meta <= asyncIn[i];
                    syncOut[i] <= meta;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: logic/sirqa_low_meter.sv */
`default_nettype none
`include "sirqa_map.svh"
// Measures consecutive low clocks on the synchronised line
module sirqa_low_meter (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic lineLow,
    output logic riseSeen,
    output logic [3:0] lowRun
);
    logic prevLow; // Line level one clock earlier

    // Rise: low last clock, high now; lowRun still holds width
    assign riseSeen = prevLow && !lineLow;

    // Run length saturates so long lows cannot wrap
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prevLow <= 1'b0;
            lowRun <= 4'h0;
        end else begin
            prevLow <= lineLow;
            if (lineLow) begin
                if (!prevLow)
                    lowRun <= 4'h1;
                else if (lowRun != `SIRQA_RUN_MAX)
                    lowRun <= lowRun + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/sirqa_agent.sv */
`default_nettype none
`include "sirqa_map.svh"
// Serial interrupt slave agent on the shared single-wire line
module sirqa_agent (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic serialIrqEnable,
    input wire logic frame3UsesSmi,
    input wire logic [15:1] irqIn,
    input wire logic system_mgmt_interrupt_n,
    input wire logic sirqIn,
    output logic sirqOut,
    output logic sirqOe,
    output logic quietMode,
    output logic cycleActive
);
    sirqa_pkg::sirqa_state_t state; // Cycle tracking state
    sirqa_pkg::sirqa_state_t next_state;
    sirqa_pkg::sirqa_phase_t phase; // Phase now on the line
    sirqa_pkg::sirqa_phase_t next_phase;
    sirqa_pkg::sirqa_mode_t mode; // Mode for next cycle
    logic [4:0] frameNum; // Frame now on the line
    logic [4:0] next_frame;
    logic next_oe; // Drive enable for next clock
    logic next_out; // Drive level for next clock
    logic lineSync; // Synchronised line level
    logic lineLow; // Line seen low
    logic riseSeen; // Low-to-high on line
    logic [3:0] lowRun; // Width of last low run
    logic [15:0] irqSync; // Synchronised inputs
    logic [16:1] frameVal; // Level carried per frame
    logic [16:1] sentVal; // Last level delivered per frame
    logic pending; // Undelivered change exists
    logic startReq; // Conditions for own start frame
    logic stopSeen; // Stop pulse ended this clock
    logic [5:0] kCnt; // Clocks since start rise

    // Line sampled through two flops: pin is asynchronous here
    sirqa_sync #(.WIDTH(1)) u_line_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(sirqIn),
        .syncOut(lineSync)
    );
    assign lineLow = !lineSync;

    // Interrupt levels come from other clock domains
    sirqa_sync #(.WIDTH(16)) u_irq_sync ( // RULE24
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn({system_mgmt_interrupt_n, irqIn}),
        .syncOut(irqSync)
    );

    // Low run widths tell stop frames from one-clock data lows
    sirqa_low_meter u_meter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .lineLow(lineLow),
        .riseSeen(riseSeen),
        .lowRun(lowRun)
    );

    // Frame map; frame 1 carries nothing so it stays high
    always_comb begin
        frameVal[1] = 1'b1; // RULE12
        // irqSync[k-1] holds IRQk, irqSync[15] the management level
        frameVal[2] = irqSync[0]; // RULE12
        // Frame 3 shared by management interrupt and IRQ2
        frameVal[3] = frame3UsesSmi ? irqSync[15] : irqSync[1];
        // Frames 4..16 carry IRQ3..IRQ15, 14 is IRQ13
        frameVal[16:4] = irqSync[14:2]; // RULE14
    end

    // Differences to the last delivered level, frame 1 ignored
    assign pending = |((frameVal ^ sentVal) & `SIRQA_FRAME1_MASK);

    // Own start only from an idle line in Quiet mode
    assign startReq = serialIrqEnable // RULE23
        && (mode == sirqa_pkg::SIRQA_QUIET) // RULE6
        && pending && !lineLow; // RULE5

    // Stop pulse ends a cycle; one-clock lows are data
    assign stopSeen = riseSeen && (lowRun >= `SIRQA_STOP_QUIET);

    // Cycle sequencing and the drive for the next clock
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_frame = frameNum;
        next_oe = 1'b0;
        next_out = 1'b0;
        unique case (state)
            sirqa_pkg::SIRQA_IDLE: begin
                // Host start wins; no own start while busy
                if (lineLow) begin
                    next_state = sirqa_pkg::SIRQA_START_LOW;
                end else if (startReq) begin // RULE16
                    next_state = sirqa_pkg::SIRQA_OWN_START; // RULE3
                    next_oe = 1'b1; // RULE2
                end
            end
            sirqa_pkg::SIRQA_OWN_START: begin
                // Released after one clock, never driven high
                if (lineLow)
                    next_state = sirqa_pkg::SIRQA_START_LOW; // RULE25
            end
            sirqa_pkg::SIRQA_START_LOW: begin
                // Rise seen two clocks late: frame 1 sample passed
                if (riseSeen) begin
                    next_state = sirqa_pkg::SIRQA_FRAMES; // RULE8
                    next_frame = `SIRQA_FIRST_FRAME; // RULE11
                    next_phase = sirqa_pkg::SIRQA_RECOVER;
                end
            end
            sirqa_pkg::SIRQA_FRAMES: begin
                if (stopSeen) begin
                    next_state = sirqa_pkg::SIRQA_IDLE; // RULE17
                end else begin
                    unique case (phase) // RULE8
                        sirqa_pkg::SIRQA_SAMPLE: begin
                            next_phase = sirqa_pkg::SIRQA_RECOVER;
                            // High only after our own low
                            next_oe = sirqOe; // RULE10
                            next_out = 1'b1;
                        end
                        sirqa_pkg::SIRQA_RECOVER: begin
                            // Turn-around always released
                            next_phase = sirqa_pkg::SIRQA_TURN; // RULE10
                        end
                        default: begin
                            next_phase = sirqa_pkg::SIRQA_SAMPLE;
                            // Saturate past last frame: host may run on
                            if (frameNum != `SIRQA_FRAME_MAX)
                                next_frame = frameNum + 5'h01;
                            // Low only for a low level we own
                            if (next_frame >= `SIRQA_FIRST_IRQ_FRAME
                                && frameNum < `SIRQA_NUM_FRAMES)
                                next_oe = !frameVal[next_frame]; // RULE9
                        end
                    endcase
                end
            end
            default: next_state = sirqa_pkg::SIRQA_IDLE;
        endcase
        // Disabled agent leaves the line alone
        if (!serialIrqEnable) // RULE1
            next_oe = 1'b0; // RULE23
        if (!next_oe)
            next_out = 1'b0;
    end

    // State, frame and phase registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= sirqa_pkg::SIRQA_IDLE; // RULE19
            phase <= sirqa_pkg::SIRQA_TURN;
            frameNum <= 5'h00;
        end else begin
            state <= next_state;
            phase <= next_phase;
            frameNum <= next_frame;
        end
    end

    // Pin drivers registered, change only on the rising edge
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sirqOe <= 1'b0; // RULE19
            sirqOut <= 1'b0;
        end else begin
            sirqOe <= next_oe; // RULE18
            sirqOut <= next_out;
        end
    end

    // Mode taken from stop width only
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode <= sirqa_pkg::SIRQA_CONT; // RULE7
        end else if (state == sirqa_pkg::SIRQA_FRAMES && stopSeen) begin
            if (lowRun == `SIRQA_STOP_QUIET)
                mode <= sirqa_pkg::SIRQA_QUIET; // RULE15
            else if (lowRun == `SIRQA_STOP_CONT)
                mode <= sirqa_pkg::SIRQA_CONT; // RULE15
        end
    end

    // Delivered levels; a change caught by a running cycle
    // is recorded here and so raises no extra start
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sentVal <= `SIRQA_SENT_RESET;
        end else if (state == sirqa_pkg::SIRQA_FRAMES
            && phase == sirqa_pkg::SIRQA_TURN && serialIrqEnable
            && !stopSeen && frameNum < `SIRQA_NUM_FRAMES) begin
            sentVal[frameNum + 5'h01] <= frameVal[frameNum + 5'h01]; // RULE5
        end
    end

    // Clock count from the start rise, for checking only
    always_ff @(posedge sys_clk) begin
        if (!rstn)
            kCnt <= 6'h00;
        else if (state == sirqa_pkg::SIRQA_START_LOW && riseSeen)
            kCnt <= `SIRQA_SYNC_DLY + 6'h01;
        else if (kCnt != `SIRQA_K_MAX)
            kCnt <= kCnt + 6'h01;
    end

    // Status outputs
    assign quietMode = (mode == sirqa_pkg::SIRQA_QUIET);
    assign cycleActive = (state != sirqa_pkg::SIRQA_IDLE);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Own start: one low clock then released
    sequence s_own_pulse;
        sirqOe && !sirqOut ##1 !sirqOe;
    endsequence
    sequence s_own_begin;
        state == sirqa_pkg::SIRQA_IDLE
            ##1 state == sirqa_pkg::SIRQA_OWN_START;
    endsequence
    property p_own_start;
        s_own_begin |-> s_own_pulse;
    endproperty
    a_own_start: assert property (p_own_start) // RULE2
        else $error("own start pulse not one low clock");

    property p_no_high_start;
        state == sirqa_pkg::SIRQA_OWN_START |-> !(sirqOe && sirqOut);
    endproperty
    a_no_high_start: assert property (p_no_high_start) // RULE2
        else $error("line driven high during own start");

    property p_quiet_only;
        s_own_begin |-> $past(mode, 1) == sirqa_pkg::SIRQA_QUIET;
    endproperty
    a_quiet_only: assert property (p_quiet_only) // RULE6
        else $error("own start issued in Continuous mode");

    property p_sample_pos;
        state == sirqa_pkg::SIRQA_FRAMES && sirqOe && !sirqOut
            |-> kCnt == {frameNum, 1'b0} + {1'b0, frameNum} - 6'h01
            && frameNum >= `SIRQA_FIRST_IRQ_FRAME
            && frameNum <= `SIRQA_NUM_FRAMES;
    endproperty
    a_sample_pos: assert property (p_sample_pos) // RULE11
        else $error("sample low at wrong clock");

    property p_recover;
        sirqOe && sirqOut |-> $past(sirqOe && !sirqOut)
            ##1 !sirqOe;
    endproperty
    a_recover: assert property (p_recover) // RULE10
        else $error("recovery high without preceding low");

    property p_disabled;
        !serialIrqEnable |=> !sirqOe;
    endproperty
    a_disabled: assert property (p_disabled) // RULE23
        else $error("line driven while disabled");

    property p_reset_release;
        // Own disable: the default one would mask the reset clocks
        @(posedge sys_clk) disable iff (1'b0) !rstn |=> !sirqOe
            && mode == sirqa_pkg::SIRQA_CONT;
    endproperty
    a_reset_release: assert property (p_reset_release) // RULE19
        else $error("line not released or mode wrong after reset");

    property p_mode_at_stop;
        mode != $past(mode) |-> $past(stopSeen)
            && $past(state) == sirqa_pkg::SIRQA_FRAMES;
    endproperty
    a_mode_at_stop: assert property (p_mode_at_stop) // RULE7
        else $error("mode changed outside a stop frame");

    property p_stop_two;
        state == sirqa_pkg::SIRQA_FRAMES && riseSeen
            && lowRun == `SIRQA_STOP_QUIET
            |=> quietMode && state == sirqa_pkg::SIRQA_IDLE;
    endproperty
    a_stop_two: assert property (p_stop_two) // RULE15
        else $error("two-clock stop did not select Quiet");

    property p_value;
        state == sirqa_pkg::SIRQA_FRAMES
            && phase == sirqa_pkg::SIRQA_SAMPLE && !sirqOe
            && frameNum >= `SIRQA_FIRST_IRQ_FRAME
            && frameNum <= `SIRQA_NUM_FRAMES
            |-> !$past(serialIrqEnable)
            || $past(frameVal[frameNum + 5'h01]);
    endproperty
    a_value: assert property (p_value) // RULE9
        else $error("low level not driven in its sample clock");

    property p_turn;
        state == sirqa_pkg::SIRQA_FRAMES
            && phase == sirqa_pkg::SIRQA_TURN |-> !sirqOe;
    endproperty
    a_turn: assert property (p_turn) // RULE10
        else $error("line driven in turn-around");
endmodule
`default_nettype wire

/* File: test/sirqa_host_model.sv */
`default_nettype none
// Host side of the line: start, sixteen frames, stop
module sirqa_host_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic lineIn,
    input wire logic goCycle,
    input wire logic [3:0] startLen,
    input wire logic [1:0] stopLen,
    output logic hostOe,
    output logic hostOut,
    output logic busy,
    output logic inFrames,
    output logic [6:0] pos,
    output logic [7:0] cycDone
);
    timeunit 1ns;
    timeprecision 100ps;
    logic quiet = 1'b0; // Mode announced by our last stop

    // Whole cycle; own means the agent gave the first low clock
    task automatic run_cycle(input logic own);
        busy <= 1'b1;
        hostOe <= 1'b1;
        hostOut <= 1'b0;
        repeat (startLen - 4'(own)) @(posedge sys_clk);
        hostOut <= 1'b1;
        inFrames <= 1'b1;
        pos <= 7'h00;
        for (int i = 1; i < 50; i++) begin
            @(posedge sys_clk);
            hostOe <= 1'b0;
            pos <= 7'(i);
        end
        @(posedge sys_clk);
        inFrames <= 1'b0;
        hostOe <= 1'b1;
        hostOut <= 1'b0;
        repeat (stopLen) @(posedge sys_clk);
        hostOut <= 1'b1;
        quiet = (stopLen == 2'h2);
        @(posedge sys_clk);
        // Turn-around; a new start may follow right after
        hostOe <= 1'b0;
        busy <= 1'b0;
        // Completion count, polled by the testbench to wait for cycles
        cycDone <= cycDone + 8'h01;
    endtask

    // Idle loop: start on request, or take over an agent's start
    initial begin
        hostOe = 1'b0;
        hostOut = 1'b0;
        busy = 1'b0;
        inFrames = 1'b0;
        cycDone = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (!rstn) begin
                quiet = 1'b0;
            end else if (goCycle) begin
                run_cycle(1'b0);
            end else if (quiet && !lineIn) begin
                run_cycle(1'b1);
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
// Agent against a host model on a pulled-up line
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic rstnD = 1'b1; // Reset level one edge ago
    logic serialIrqEnable = 1'b1;
    logic frame3UsesSmi = 1'b0;
    logic smiN = 1'b1;
    logic [15:1] irqIn = 15'h7FFF;
    logic goCycle = 1'b0;
    logic [3:0] startLen = 4'h4;
    logic [1:0] stopLen = 2'h3;
    logic sirqOut, sirqOe, quietMode, cycleActive, sirqLine;
    logic hostOe, hostOut, busy, inFrames;
    logic busyD = 1'b0; // Host busy one edge ago
    logic [6:0] pos;
    logic [7:0] cycDone;
    logic expQuiet = 1'b0; // Mode the bench expects
    logic lastDrove = 1'b0;
    logic drv;
    int fails = 0;
    int nCompared = 0;
    int seed = 32'h1A46;
    int ownStarts = 0; // Lone start lows seen
    int cycles = 0;
    int n, ph, k;

    always #4 sys_clk = ~sys_clk;
    // Pull-up: low when any party drives low
    assign sirqLine = ((hostOe && !hostOut) || (sirqOe && !sirqOut))
        ? 1'b0 : 1'b1;

    sirqa_agent i_sirqa_agent (
        .sys_clk(sys_clk), .rstn(rstn), .serialIrqEnable(serialIrqEnable),
        .frame3UsesSmi(frame3UsesSmi), .irqIn(irqIn),
        .system_mgmt_interrupt_n(smiN), .sirqIn(sirqLine),
        .sirqOut(sirqOut), .sirqOe(sirqOe), .quietMode(quietMode),
        .cycleActive(cycleActive));
    sirqa_host_model i_sirqa_host_model (
        .sys_clk(sys_clk), .rstn(rstn), .lineIn(sirqLine),
        .goCycle(goCycle), .startLen(startLen), .stopLen(stopLen),
        .hostOe(hostOe), .hostOut(hostOut), .busy(busy),
        .inFrames(inFrames), .pos(pos), .cycDone(cycDone));

    task automatic check_bit(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t bit %b want %b", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        nCompared++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED t=%0t count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, failed %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Level carried by frame f
    function automatic logic frame_val(input int f);
        if (f == 3) return frame3UsesSmi ? smiN : irqIn[2];
        return irqIn[f - 1];
    endfunction

    // New levels; the unused frame 3 source stays high
    task automatic rnd_irq(input logic smi);
        frame3UsesSmi <= smi;
        irqIn <= 15'($random(seed)) | (smi ? 15'h0002 : 15'h0000);
        smiN <= smi ? 1'($random(seed)) : 1'b1;
    endtask

    task automatic wait_done(input int target);
        int w;
        w = 0;
        while (cycDone != 8'(target) && w < 600) begin
            @(posedge sys_clk);
            w++;
        end
        if (w == 600) begin
            fails++;
            end_sim();
        end
        expQuiet = (stopLen == 2'h2);
        repeat (3) @(posedge sys_clk);
        if (serialIrqEnable) check_bit(quietMode, expQuiet);
    endtask

    // Host runs cnt cycles back to back
    task automatic host_cycle(input logic [3:0] sl, input logic [1:0] st,
        input int cnt);
        int w, b;
        b = cycDone;
        w = 0;
        startLen <= sl;
        stopLen <= st;
        goCycle <= 1'b1;
        while (!(busy && cycDone == 8'(b + cnt - 1)) && w < 400) begin
            @(posedge sys_clk);
            w++;
        end
        goCycle <= 1'b0;
        wait_done(b + cnt);
    endtask

    // A level change must bring exactly one agent start
    task automatic own_cycle(input logic [1:0] st);
        int b;
        b = ownStarts;
        stopLen <= st;
        startLen <= 4'(4 + $unsigned($random(seed)) % 5);
        irqIn <= irqIn ^ (15'($random(seed)) | 15'h0001);
        wait_done(cycDone + 1);
        check_count(ownStarts, b + 1);
    endtask

    // Line monitor: frame drive, idle silence, reset state
    always @(posedge sys_clk) begin
        cycles++;
        rstnD <= rstn;
        busyD <= busy;
        if (cycles > 20000) begin
            fails++;
            end_sim();
        end
        if (!rstn && !rstnD) begin
            check_bit(sirqOe, 1'b0);
            check_bit(quietMode, 1'b0);
            check_bit(cycleActive, 1'b0);
        end else if (inFrames) begin
            n = (pos + 1) / 3;
            ph = (pos + 1) % 3;
            if (serialIrqEnable) check_bit(quietMode, expQuiet);
            if (pos == 7'h14) check_bit(cycleActive, 1'b1);
            if (ph == 0) begin
                drv = serialIrqEnable && n > 1 && n < 17 && !frame_val(n);
                check_bit(sirqOe, drv);
                if (drv) check_bit(sirqOut, 1'b0);
                lastDrove = drv;
            end else if (ph == 1) begin
                check_bit(sirqOe, lastDrove);
                if (lastDrove) check_bit(sirqOut, 1'b1);
                lastDrove = 1'b0;
            end else begin
                check_bit(sirqOe, 1'b0);
            end
        end else if (sirqOe === 1'b1) begin
            // Only a lone low from an idle quiet line
            check_bit(sirqOut, 1'b0);
            check_bit(!busy && !busyD && expQuiet && serialIrqEnable, 1'b1);
            ownStarts++;
        end else if (rstn && rstnD) begin
            check_bit(sirqOe, 1'b0);
        end
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        for (k = 0; k < 6; k++) begin
            rnd_irq(k[0]);
            repeat (4) @(posedge sys_clk);
            host_cycle(4'(4 + $unsigned($random(seed)) % 5), 2'h3, 1);
        end
        host_cycle(4'h8, 2'h3, 3);
        check_count(ownStarts, 0);
        host_cycle(4'h4, 2'h2, 1);
        repeat (30) @(posedge sys_clk);
        check_count(ownStarts, 0);
        for (k = 0; k < 4; k++) own_cycle(k == 3 ? 2'h3 : 2'h2);
        irqIn <= ~irqIn;
        repeat (30) @(posedge sys_clk);
        check_count(ownStarts, 4);
        // Line is in Continuous mode before the agent is switched off
        serialIrqEnable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        host_cycle(4'h6, 2'h2, 1);
        irqIn <= ~irqIn;
        repeat (30) @(posedge sys_clk);
        check_count(ownStarts, 4);
        rstn <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        serialIrqEnable <= 1'b1;
        expQuiet = 1'b0;
        host_cycle(4'h5, 2'h3, 1);
        end_sim();
    end
endmodule
`default_nettype wire
